// >>> bench/dtec_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

module dtec_pulse_src
(
  input  wire logic hclk,
  output logic      external_count_pin,
  output logic      counter_input_pin
);
  // both sources rest low between pulses
  initial
  begin
    external_count_pin = 1'b0;
    counter_input_pin  = 1'b0;
  end

  // one high pulse of n cycles, changed just after an edge
  task automatic ci_pulse(input int n);
    @(posedge hclk);
    counter_input_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    counter_input_pin <= 1'b0;
  endtask : ci_pulse

  // n rising edges on the timer pin, two cycles high and three low each
  task automatic tc_pulses(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      external_count_pin <= 1'b1;
      repeat (2) @(posedge hclk);
      external_count_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
  endtask : tc_pulses
endmodule : dtec_pulse_src
`default_nettype wire

// >>> bench/test_dual_timer_event_counter.sv
`timescale 1ns/1ps
`default_nettype none

module test_dual_timer_event_counter;
  import dtec_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_ph, xc, ci, sq, wa, wb;
  logic t0i, t1i, c0i, c1i, eci;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, v, seed;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_count, total_checks, cyc, n;
  logic        s0, run_en, stop_pin;
  logic [2:0]  irqs;

  dtec_top dtec_top_i (.hclk(hclk), .hresetn(hresetn), .ce(run_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .external_count_pin(xc), .counter_input_pin(ci), .hw_stop_pin(stop_pin),
    .square_wave_pin(sq), .wave_out_a(wa), .wave_out_b(wb), .timer0_match_irq(t0i),
    .timer1_match_irq(t1i), .compare_zero_irq(c0i), .compare_one_irq(c1i),
    .edge_capture_irq(eci));
  dtec_pulse_src dtec_pulse_src_i (.hclk(hclk), .external_count_pin(xc),
    .counter_input_pin(ci));

  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // single word transfer; a read notes its expected value for the monitor
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= ~w;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph  <= 1'b0;
  endtask : bus

  // pulses that gap can wait for: [0] timer0, [1] compare zero, [2] compare one
  assign irqs = {c1i, c0i, t0i};

  // cycles until the next pulse of the chosen interrupt, bounded
  task automatic gap(input int sel, output int k);
    k = 1;
    @(posedge hclk);
    while (irqs[sel] !== 1'b1 && k < 3000)
    begin
      @(posedge hclk);
      k++;
    end
  endtask : gap

  // read data is taken at the edge that ends the data phase
  always @(posedge hclk)
    if (rd_ph === 1'b1)
    begin
      chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
      chk("hresp", {31'h0, hresp}, 32'h0);
    end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      test_done;
    end
  end

  initial
  begin
    {hsel, hwrite, rd_ph, htrans, haddr, hwdata, stop_pin} = '0;
    run_en = 1'b1;
    seed = 32'ha832;
    hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(A_TMR_CTL, 0, 32'h0000_00ff, '1);
    bus(A_EVT_CTL, 0, 32'h0, '1);
    bus(A_OUT_CTL, 0, 32'h0, '1);
    bus(8'h3c, 0, 32'h0, '1);
    $display("reset values done");
    // timer0 on osc/12, square wave toggles on its match
    bus(A_TMR0_CMP, 1, 32'h3, 0);
    bus(A_TMR_CTL, 1, 32'h80, 0);
    gap(0, n);
    s0 = sq;
    gap(0, n);
    chk("t0 interval", n, 36);
    chk("square toggle", {31'h0, sq}, {31'h0, ~s0});
    // ten frozen cycles push the next match ten cycles out
    run_en <= 1'b0;
    repeat (10) @(posedge hclk);
    run_en <= 1'b1;
    gap(0, n);
    chk("frozen interval", n, 36);
    bus(A_IRQ_MASK, 1, 32'h2, 0);
    gap(0, n);
    chk("masked irq", n, 3000);
    bus(A_TMR_CTL, 1, 32'h90, 0);
    // one idle cycle, so the halted count has reached the status word
    @(posedge hclk);
    bus(A_TMR_STAT, 0, 32'h0, 32'hff);
    // timer0 counts rising edges of its pin, starting from zero
    bus(A_TMR_CTL, 1, 32'h8b, 0);
    dtec_pulse_src_i.tc_pulses(2);
    bus(A_TMR_STAT, 0, 32'h2, 32'hff);
    $display("timer done");
    // pulse width mode: fall captures, clears and interrupts
    bus(A_EVT_CTL, 1, 32'h09, 0);
    dtec_pulse_src_i.ci_pulse(120);
    n = 0;
    while (eci !== 1'b1 && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    chk("edge irq", {31'h0, eci}, 32'h1);
    bus(A_EVT_COUNT, 0, 32'h0, '1);
    bus(A_EVT_CAPT, 0, 32'ha, '1);
    $display("pulse width done");
    // set then reset each level, driven to its pin; request bits clear themselves
    for (int ch = 0; ch < 2; ch++)
    begin
      bus(A_OUT_CTL, 1, 32'h09 << (4 * ch), 0);
      repeat (3) @(posedge hclk);
      chk("out set", {wb, wa}, 2'b01 << ch);
      bus(A_OUT_CTL, 0, 32'h0, '1);
      bus(A_OUT_CTL, 1, 32'h05 << (4 * ch), 0);
      repeat (3) @(posedge hclk);
      chk("out reset", {wb, wa}, 2'b00);
    end
    $display("outputs done");
    // compare zero takes software values, only the low 16 bits stored
    repeat (4)
    begin
      v = $random(seed);
      bus(A_EVT_CMP0, 1, v, 0);
      bus(A_EVT_CMP0, 0, {16'h0, v[15:0]}, '1);
    end
    $display("random done");
    // square wave: compare zero below compare one, counter cleared by the start write
    bus(A_EVT_CMP0, 1, 32'h2, 0);
    bus(A_EVT_CMP1, 1, 32'h5, 0);
    bus(A_OUT_CTL, 1, 32'haa, 0);
    bus(A_EVT_CTL, 1, 32'hf5, 0);
    gap(1, n);
    chk("level out at m0", {wb, wa}, 2'b11);
    gap(2, n);
    chk("m0 to m1", n, 36);
    chk("level out at m1", {wb, wa}, 2'b00);
    $display("square wave done");
    // hardware stop clears both mode registers, the lasting flip bits too
    stop_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(A_EVT_CTL, 0, 32'h0, '1);
    bus(A_OUT_CTL, 0, 32'h0, '1);
    stop_pin <= 1'b0;
    $display("hardware stop done");
    test_done;
  end
endmodule : test_dual_timer_event_counter
`default_nettype wire

// >>> common/dtec_pkg.sv
package dtec_pkg;

  // register byte offsets on the bus (word aligned)
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  A_TMR0_CMP      = 8'h00;
  localparam logic [7:0]  A_TMR1_CMP      = 8'h04;
  localparam logic [7:0]  A_TMR_CTL       = 8'h08;
  localparam logic [7:0]  A_EVT_CAPT      = 8'h0c;
  localparam logic [7:0]  A_EVT_CMP0      = 8'h10;
  localparam logic [7:0]  A_EVT_CMP1      = 8'h14;
  localparam logic [7:0]  A_EVT_CTL       = 8'h18;
  localparam logic [7:0]  A_OUT_CTL       = 8'h1c;
  localparam logic [7:0]  A_IRQ_MASK      = 8'h20;
  localparam logic [7:0]  A_EVT_COUNT     = 8'h24;
  localparam logic [7:0]  A_TMR_STAT      = 8'h28;

  // reset values
  localparam logic [7:0]  TMR_CTL_RST     = 8'hff;
  localparam logic [7:0]  EVT_CTL_RST     = 8'h00;
  localparam logic [7:0]  OUT_CTL_RST     = 8'h00;
  localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;

  // timer_control fields
  localparam int unsigned TC_FF_LSB       = 0;
  localparam int unsigned TC_T0_SRC_LSB   = 2;
  localparam int unsigned TC_T0_HALT      = 4;
  localparam int unsigned TC_T1_SRC_LSB   = 5;
  localparam int unsigned TC_T1_HALT      = 7;
  localparam int unsigned MASK_T0_BIT     = 1;

  // event_control fields
  localparam int unsigned EC_SRC_LSB      = 0;
  localparam int unsigned EC_CLR_M1       = 2;
  localparam int unsigned EC_CLR_EDGE     = 3;
  localparam int unsigned EC_OUT_LSB      = 4;
  localparam int unsigned EC_OUT_STRIDE   = 2;

  // output_control fields, per channel at a stride of four
  localparam int unsigned OC_DRIVE        = 0;
  localparam int unsigned OC_FLIP         = 1;
  localparam int unsigned OC_RST          = 2;
  localparam int unsigned OC_SET          = 3;
  localparam int unsigned OC_STRIDE       = 4;
  localparam logic [7:0]  OC_AUTO_CLR     = 8'hdd;

  // oscillator dividers
  localparam int unsigned DIV_FAST        = 3;
  localparam int unsigned DIV_MID         = 12;
  localparam int unsigned DIV_SLOW        = 384;
  localparam logic [1:0]  DIV_FAST_LAST   = 2'(DIV_FAST - 1);
  localparam logic [3:0]  DIV_MID_LAST    = 4'(DIV_MID - 1);
  localparam logic [8:0]  DIV_SLOW_LAST   = 9'(DIV_SLOW - 1);

  // bus codes
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  typedef enum logic [1:0] {
    TSRC_DIV12   = 2'h0,
    TSRC_DIV384  = 2'h1,
    TSRC_PIN     = 2'h2,
    TSRC_CASCADE = 2'h3
  } dtec_tsrc_t;

  typedef enum logic [1:0] {
    FF_T0_MATCH = 2'h0,
    FF_T1_MATCH = 2'h1,
    FF_DIV3     = 2'h2,
    FF_HOLD     = 2'h3
  } dtec_ffmode_t;

  typedef enum logic [1:0] {
    ESRC_OFF   = 2'h0,
    ESRC_DIV12 = 2'h1,
    ESRC_PIN   = 2'h2,
    ESRC_WAVE  = 2'h3
  } dtec_esrc_t;

endpackage : dtec_pkg

// >>> design/dtec_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dtec_interval_timer
  import dtec_pkg::*;
#(
  parameter int unsigned CW = 8
)
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  input  wire logic          halt,
  input  wire logic          tick,
  input  wire logic [CW-1:0] compare,
  output logic      [CW-1:0] count,
  output logic               match
);

  typedef struct packed {
    logic [CW-1:0] cnt_r;
    logic          match_r;
  } dtec_tmr_t;

  dtec_tmr_t s_r;
  dtec_tmr_t s_nxt;
  logic [CW-1:0] sum;

  if (CW < 2)
  begin : g_bad_width
    $error("dtec_interval_timer needs a counter of two bits or more");
  end

  assign sum = s_r.cnt_r + CW'(1);

  // halted counter sits at zero, so release always starts from zero
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.match_r = 1'b0;
    if (halt)
      s_nxt.cnt_r = '0;  // see R8
    else if (tick)
    begin
      if (sum == compare)
      begin
        s_nxt.cnt_r   = '0;  // see R3
        s_nxt.match_r = 1'b1;
      end
      else
        s_nxt.cnt_r = sum;  // see R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign count = s_r.cnt_r;
  assign match = s_r.match_r;

  halt_holds_zero_a : assert property (  // see R8
    @(posedge hclk) disable iff (!hresetn)
    (ce && halt) |=> (count == '0) && !match)
    else $error("halted timer did not sit at zero");

  match_restart_a : assert property (  // see R3
    @(posedge hclk) disable iff (!hresetn)
    (ce && !halt && tick && (sum == compare)) |=> match && (count == '0) ##1 !match || !ce)
    else $error("timer match did not restart from zero");

endmodule : dtec_interval_timer

`default_nettype wire

// >>> design/dtec_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module dtec_pin_sync
  import dtec_pkg::*;
#(
  parameter int unsigned WIDTH = 3
)
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  typedef struct packed {
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;
  } dtec_sync_t;

  dtec_sync_t s_r;
  dtec_sync_t s_nxt;

  if (WIDTH == 0)
  begin : g_bad_width
    $error("dtec_pin_sync needs at least one pin");
  end

  // two stages against metastability, a third only for edges
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.meta_r = pin_in;
    s_nxt.sync_r = s_r.meta_r;
    s_nxt.prev_r = s_r.sync_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign level = s_r.sync_r;

  // edge detect looks only at settled stages, never at meta_r
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_edge
    assign rise[i] = s_r.sync_r[i] & ~s_r.prev_r[i];  // see R21
    assign fall[i] = ~s_r.sync_r[i] & s_r.prev_r[i];  // see R21
  end

endmodule : dtec_pin_sync

`default_nettype wire

// >>> design/dtec_top.sv
// Contract
// R1: two 8-bit interval timers, cascadable into one 16-bit timer or input counter.
// R2: timer0 counts osc/12, osc/384 or input pin; timer1 also timer0 match.
// R3: upcounter increments per input; on compare match it interrupts and restarts at zero.
// R4: mask bit 1 of low mask register suppresses the timer0 match interrupt.
// R5: timer flip-flop toggles on selected match or osc/3, giving a square wave.
// R6: square wave feeds event counter reference and serves as serial clock.
// R7: timer control: ff mode, timer0 source, halt, timer1 source, halt.
// R8: halt bit holds upcounter at zero; release starts counting from zero.
// R9: reset sets timer control all ones, clears counters and the flip-flop.
// R10: capture on input pin fall for internal clock, on wave fall for pin.
// R11: separate interrupts for compare zero, compare one and capture edge.
// R12: pulse width mode counts osc/12 while pin high; fall captures, clears, interrupts.
// R13: each counter output is a level flip-flop followed by an output latch.
// R14: selected match drives level out, inverts if enabled; compare one may clear.
// R15: event control: clock select, clear mode, output a timing, output b timing.
// R16: reset or hardware stop clears the event control register.
// R17: output control: drive enables, inversion enables, set/reset requests per output.
// R18: drive enables and set/reset requests clear themselves after acting.
// R19: reset or hardware stop clears the output control register.
// R20: software clears counter and sets compare zero below compare one first.
// R21: external pins are synchronised and edge detected before use.
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module dtec_top
  import dtec_pkg::*;
#(
  parameter int unsigned NUM_OUT = 2
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        external_count_pin,
  input  wire logic        counter_input_pin,
  input  wire logic        hw_stop_pin,
  output logic             square_wave_pin,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             timer0_match_irq,
  output logic             timer1_match_irq,
  output logic             compare_zero_irq,
  output logic             compare_one_irq,
  output logic             edge_capture_irq
);

  if (NUM_OUT != 2)
  begin : g_bad_outputs
    $error("output control layout serves exactly two counter outputs");
  end

  typedef struct packed {
    logic [1:0]         c3_r;
    logic [3:0]         c12_r;
    logic [8:0]         c384_r;
    logic [7:0]         tmr0_cmp_r;
    logic [7:0]         tmr1_cmp_r;
    logic [7:0]         tmr_ctl_r;
    logic [7:0]         irq_mask_r;
    logic [15:0]        event_upcounter_r;
    logic [15:0]        event_capture_r;
    logic [15:0]        ecmp0_r;
    logic [15:0]        ecmp1_r;
    logic [7:0]         ectl_r;
    logic [7:0]         octl_r;
    logic [NUM_OUT-1:0] level_r;
    logic [NUM_OUT-1:0] wave_r;
    logic               sq_r;
    logic               t0_irq_r;
    logic               t1_irq_r;
    logic               cz_irq_r;
    logic               co_irq_r;
    logic               edge_irq_r;
    logic               wr_pend_r;
    logic [7:0]         wr_addr_r;
    logic [31:0]        rdata_r;
    logic               ready_r;
  } dtec_state_t;

  localparam dtec_state_t S_RST = '{tmr_ctl_r: TMR_CTL_RST, ectl_r: EVT_CTL_RST,
                                    octl_r: OUT_CTL_RST, irq_mask_r: IRQ_MASK_RST,
                                    ready_r: 1'b1, default: '0};

  dtec_state_t        s_r;
  dtec_state_t        s_nxt;
  logic [2:0]         pin_level;
  logic [2:0]         pin_rise;
  logic [2:0]         pin_fall;
  logic               tick3;
  logic               tick12;
  logic               tick384;
  logic               t0_tick;
  logic               t1_tick;
  logic               t0_match;
  logic               t1_match;
  logic [7:0]         t0_count;
  logic [7:0]         t1_count;
  logic               ff_toggle;
  logic               wave_rise;
  logic               wave_fall;
  logic               ev_inc;
  logic [15:0]        ev_sum;
  logic               ev_m0;
  logic               ev_m1;
  logic               ev_edge;
  logic               ev_clear;
  logic               pw_mode;
  logic [NUM_OUT-1:0] fire;
  logic               bus_acc;
  dtec_tsrc_t         t0_src;
  dtec_tsrc_t         t1_src;
  dtec_ffmode_t       ff_mode;
  dtec_esrc_t         ev_src;

  // pins: [0] timer count input, [1] counter input, [2] hardware stop
  dtec_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .pin_in  ({hw_stop_pin, counter_input_pin, external_count_pin}),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // oscillator divided ticks, one cycle wide
  assign tick3   = (s_r.c3_r == DIV_FAST_LAST);
  assign tick12  = (s_r.c12_r == DIV_MID_LAST);
  assign tick384 = (s_r.c384_r == DIV_SLOW_LAST);

  assign t0_src  = dtec_tsrc_t'(s_r.tmr_ctl_r[TC_T0_SRC_LSB +: 2]);
  assign t1_src  = dtec_tsrc_t'(s_r.tmr_ctl_r[TC_T1_SRC_LSB +: 2]);
  assign ff_mode = dtec_ffmode_t'(s_r.tmr_ctl_r[TC_FF_LSB +: 2]);

  // timer source select; timer0 has no cascade input, so that code leaves it idle
  always_comb
  begin
    unique case (t0_src)  // see R2
      TSRC_DIV12:   t0_tick = tick12;
      TSRC_DIV384:  t0_tick = tick384;
      TSRC_PIN:     t0_tick = pin_rise[0];  // see R21
      TSRC_CASCADE: t0_tick = 1'b0;
    endcase
    unique case (t1_src)  // see R2
      TSRC_DIV12:   t1_tick = tick12;
      TSRC_DIV384:  t1_tick = tick384;
      TSRC_PIN:     t1_tick = pin_rise[0];
      TSRC_CASCADE: t1_tick = t0_match;  // see R1
    endcase
    unique case (ff_mode)  // see R5
      FF_T0_MATCH:  ff_toggle = t0_match;
      FF_T1_MATCH:  ff_toggle = t1_match;
      FF_DIV3:      ff_toggle = tick3;
      FF_HOLD:      ff_toggle = 1'b0;
    endcase
  end

  dtec_interval_timer #(
    .CW (8)
  ) u_timer0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .halt    (s_r.tmr_ctl_r[TC_T0_HALT]),  // see R7
    .tick    (t0_tick),
    .compare (s_r.tmr0_cmp_r),
    .count   (t0_count),
    .match   (t0_match)
  );

  dtec_interval_timer #(
    .CW (8)
  ) u_timer1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .halt    (s_r.tmr_ctl_r[TC_T1_HALT]),  // see R7
    .tick    (t1_tick),
    .compare (s_r.tmr1_cmp_r),
    .count   (t1_count),
    .match   (t1_match)
  );

  // square wave edges are internal, no synchroniser needed
  assign wave_rise = ff_toggle & ~s_r.sq_r;
  assign wave_fall = ff_toggle & s_r.sq_r;

  // event counter input, compare and capture edge
  assign ev_src  = dtec_esrc_t'(s_r.ectl_r[EC_SRC_LSB +: 2]);  // see R15
  assign pw_mode = s_r.ectl_r[EC_CLR_EDGE];
  always_comb
  begin
    unique case (ev_src)
      ESRC_OFF:   ev_inc = 1'b0;
      ESRC_DIV12: ev_inc = tick12 & (~pw_mode | pin_level[1]);  // see R12
      ESRC_PIN:   ev_inc = pin_fall[1];
      ESRC_WAVE:  ev_inc = wave_rise;  // see R6
    endcase
  end

  assign ev_sum   = s_r.event_upcounter_r + 16'h1;
  assign ev_m0    = ev_inc & (ev_sum == s_r.ecmp0_r);
  assign ev_m1    = ev_inc & (ev_sum == s_r.ecmp1_r);
  assign ev_edge  = (ev_src == ESRC_PIN) ? wave_fall : pin_fall[1];  // see R10
  assign ev_clear = (ev_m1 & s_r.ectl_r[EC_CLR_M1]) | (ev_edge & pw_mode);  // see R14

  // output timing per channel: low bit on compare zero, high bit on compare one
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_fire
    assign fire[i] = (ev_m0 & s_r.ectl_r[EC_OUT_LSB + EC_OUT_STRIDE * i])
                   | (ev_m1 & s_r.ectl_r[EC_OUT_LSB + EC_OUT_STRIDE * i + 1]);
  end

  assign bus_acc = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);

  // one next-state process for the whole block
  always_comb
  begin
    s_nxt = s_r;

    // dividers run free
    s_nxt.c3_r   = (s_r.c3_r == DIV_FAST_LAST) ? '0 : s_r.c3_r + 2'h1;
    s_nxt.c12_r  = (s_r.c12_r == DIV_MID_LAST) ? '0 : s_r.c12_r + 4'h1;
    s_nxt.c384_r = (s_r.c384_r == DIV_SLOW_LAST) ? '0 : s_r.c384_r + 9'h1;

    // timer flip-flop
    if (ff_toggle)
      s_nxt.sq_r = ~s_r.sq_r;  // see R5

    // event counter and capture
    if (ev_edge)
      s_nxt.event_capture_r = s_r.event_upcounter_r;  // see R10 R12
    if (ev_clear)
      s_nxt.event_upcounter_r = '0;  // see R12 R14
    else if (ev_inc)
      s_nxt.event_upcounter_r = ev_sum;

    // master-slave counter outputs; a match in the same cycle as a set/reset wins
    for (int i = 0; i < NUM_OUT; i++)
    begin
      if (s_r.octl_r[OC_STRIDE * i + OC_SET])
        s_nxt.level_r[i] = 1'b1;  // see R17
      else if (s_r.octl_r[OC_STRIDE * i + OC_RST])
        s_nxt.level_r[i] = 1'b0;  // see R17
      if (s_r.octl_r[OC_STRIDE * i + OC_DRIVE])
        s_nxt.wave_r[i] = s_nxt.level_r[i];  // see R13
      if (fire[i])
      begin
        s_nxt.wave_r[i] = s_r.level_r[i];  // see R13 R14
        if (s_r.octl_r[OC_STRIDE * i + OC_FLIP])
          s_nxt.level_r[i] = ~s_r.level_r[i];  // see R14
      end
    end
    s_nxt.octl_r = s_r.octl_r & ~OC_AUTO_CLR;  // see R18

    // interrupt pulses
    s_nxt.t0_irq_r   = t0_match & ~s_r.irq_mask_r[MASK_T0_BIT];  // see R4
    s_nxt.t1_irq_r   = t1_match;
    s_nxt.cz_irq_r   = ev_m0;  // see R11
    s_nxt.co_irq_r   = ev_m1;  // see R11
    s_nxt.edge_irq_r = ev_edge;  // see R11 R12

    // bus address phase: latch write target, fetch read data
    s_nxt.wr_pend_r = bus_acc & hwrite;
    if (bus_acc)
      s_nxt.wr_addr_r = haddr[ADDR_W-1:0];
    if (bus_acc && !hwrite)
    begin
      case (haddr[ADDR_W-1:0])
        A_TMR0_CMP:  s_nxt.rdata_r = {24'h0, s_r.tmr0_cmp_r};
        A_TMR1_CMP:  s_nxt.rdata_r = {24'h0, s_r.tmr1_cmp_r};
        A_TMR_CTL:   s_nxt.rdata_r = {24'h0, s_r.tmr_ctl_r};
        A_EVT_CAPT:  s_nxt.rdata_r = {16'h0, s_r.event_capture_r};
        A_EVT_CMP0:  s_nxt.rdata_r = {16'h0, s_r.ecmp0_r};
        A_EVT_CMP1:  s_nxt.rdata_r = {16'h0, s_r.ecmp1_r};
        A_EVT_CTL:   s_nxt.rdata_r = {24'h0, s_r.ectl_r};
        A_OUT_CTL:   s_nxt.rdata_r = {24'h0, s_r.octl_r};
        A_IRQ_MASK:  s_nxt.rdata_r = {24'h0, s_r.irq_mask_r};
        A_EVT_COUNT: s_nxt.rdata_r = {16'h0, s_r.event_upcounter_r};
        A_TMR_STAT:  s_nxt.rdata_r = {11'h0, s_r.wave_r, s_r.level_r, s_r.sq_r,
                                      t1_count, t0_count};
        default:     s_nxt.rdata_r = 32'h0;
      endcase
    end

    // bus data phase: software writes override hardware updates other than the hardware stop
    if (s_r.wr_pend_r)
    begin
      case (s_r.wr_addr_r)
        A_TMR0_CMP: s_nxt.tmr0_cmp_r = hwdata[7:0];
        A_TMR1_CMP: s_nxt.tmr1_cmp_r = hwdata[7:0];
        A_TMR_CTL:  s_nxt.tmr_ctl_r  = hwdata[7:0];  // see R7
        A_EVT_CMP0: s_nxt.ecmp0_r    = hwdata[15:0];
        A_EVT_CMP1: s_nxt.ecmp1_r    = hwdata[15:0];
        A_EVT_CTL:
        begin
          s_nxt.ectl_r = hwdata[7:0];  // see R15
          s_nxt.event_upcounter_r = '0;  // see R20
        end
        A_OUT_CTL:  s_nxt.octl_r     = hwdata[7:0];  // see R17
        A_IRQ_MASK: s_nxt.irq_mask_r = hwdata[7:0];  // see R4
        default:    s_nxt.ready_r    = 1'b1;
      endcase
    end

    // hardware stop level beats any write
    if (pin_level[2])
    begin
      s_nxt.ectl_r = EVT_CTL_RST;  // see R16
      s_nxt.octl_r = OUT_CTL_RST;  // see R19
    end
  end

  // reset loads constants only; ce low freezes everything, bus included
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= S_RST;  // see R9 R16 R19
    else if (ce)
      s_r <= s_nxt;
  end

  assign hreadyout        = s_r.ready_r;
  assign hrdata           = s_r.rdata_r;
  assign hresp            = 1'b0 & s_r.ready_r;
  assign square_wave_pin  = s_r.sq_r;  // see R6
  assign wave_out_a       = s_r.wave_r[0];
  assign wave_out_b       = s_r.wave_r[1];
  assign timer0_match_irq = s_r.t0_irq_r;
  assign timer1_match_irq = s_r.t1_irq_r;
  assign compare_zero_irq = s_r.cz_irq_r;
  assign compare_one_irq  = s_r.co_irq_r;
  assign edge_capture_irq = s_r.edge_irq_r;

  timer0_mask_gate_a : assert property (  // see R4
    @(posedge hclk) disable iff (!hresetn)
    (ce && t0_match) |=> (timer0_match_irq == !$past(s_r.irq_mask_r[MASK_T0_BIT])))
    else $error("timer0 interrupt not gated by its mask");

  wave_toggle_a : assert property (  // see R5
    @(posedge hclk) disable iff (!hresetn)
    (ce && ff_toggle) |=> (square_wave_pin != $past(square_wave_pin)))
    else $error("square wave did not toggle");

  capture_load_a : assert property (  // see R10
    @(posedge hclk) disable iff (!hresetn)
    (ce && ev_edge) |=> (s_r.event_capture_r == $past(s_r.event_upcounter_r)) && edge_capture_irq)
    else $error("capture edge did not load counter value");

  pulse_width_clear_a : assert property (  // see R12
    @(posedge hclk) disable iff (!hresetn)
    (ce && ev_edge && pw_mode && !s_r.wr_pend_r) |=> (s_r.event_upcounter_r == 16'h0))
    else $error("pulse width edge did not clear counter");

  match_one_clear_a : assert property (  // see R14
    @(posedge hclk) disable iff (!hresetn)
    (ce && ev_m1 && s_r.ectl_r[EC_CLR_M1]) |=> (s_r.event_upcounter_r == 16'h0) && compare_one_irq)
    else $error("compare one match did not clear counter");

  output_drive_a : assert property (  // see R13
    @(posedge hclk) disable iff (!hresetn)
    (ce && fire[0]) |=> (wave_out_a == $past(s_r.level_r[0])))
    else $error("output latch did not take the level");

  level_invert_a : assert property (  // see R14
    @(posedge hclk) disable iff (!hresetn)
    (ce && fire[1] && s_r.octl_r[OC_STRIDE + OC_FLIP] && !pin_level[2])
      |=> (s_r.level_r[1] != $past(s_r.level_r[1])))
    else $error("level did not invert at output time");

  auto_clear_a : assert property (  // see R18
    @(posedge hclk) disable iff (!hresetn)
    (ce && !s_r.wr_pend_r) |=> ((s_r.octl_r & OC_AUTO_CLR) == 8'h0))
    else $error("self clearing output bits stayed set");

  hw_stop_clear_a : assert property (  // see R16 R19
    @(posedge hclk) disable iff (!hresetn)
    (ce && pin_level[2]) |=> (s_r.ectl_r == EVT_CTL_RST) && (s_r.octl_r == OUT_CTL_RST))
    else $error("hardware stop did not clear mode registers");

endmodule : dtec_top

`default_nettype wire
